/* File: include/dmsp_pkg.sv */
// constants, types and helpers for the dual mode serial port
// assumes a single 25 MHz clock domain and a synchronous reset
package dmsp_pkg;

  localparam int DMSP_AW = 4;
  localparam int DMSP_DW = 16;
  localparam int DMSP_CW = 11;
  localparam int DMSP_IW = 5;
  localparam int DMSP_DIV_W = 7;

  localparam logic [3:0] DMSP_OFS_CTRL = 4'h0;
  localparam logic [3:0] DMSP_OFS_STAT = 4'h4;
  localparam logic [3:0] DMSP_OFS_DATA = 4'h8;
  localparam logic [3:0] DMSP_OFS_IEN  = 4'hc;

  localparam logic [1:0] DMSP_MODE_ASYNC = 2'h0;
  localparam logic [1:0] DMSP_MODE_MP    = 2'h1;
  localparam logic [1:0] DMSP_MODE_SYNC  = 2'h2;

  localparam logic [1:0] DMSP_CS_GEN = 2'h0;
  localparam logic [1:0] DMSP_CS_EXT = 2'h1;
  localparam logic [1:0] DMSP_CS_RLT = 2'h2;

  // eight clock ticks make one bit
  localparam logic [2:0] DMSP_TICK_LAST   = 3'h7;
  localparam logic [2:0] DMSP_TICK_SAMPLE = 3'h3;
  localparam logic [2:0] DMSP_TICK_SCK_HI = 3'h4;
  localparam logic [2:0] DMSP_IDX_LAST8   = 3'h7;
  localparam logic [2:0] DMSP_IDX_LAST7   = 3'h6;

  localparam int DMSP_ST_RXAV   = 0;
  localparam int DMSP_ST_FE     = 1;
  localparam int DMSP_ST_PE     = 2;
  localparam int DMSP_ST_ORE    = 3;
  localparam int DMSP_ST_TXDONE = 4;
  localparam int DMSP_ST_TXRDY  = 5;
  localparam int DMSP_ST_TXBUSY = 6;

  localparam logic [DMSP_CW-1:0] DMSP_CTRL_RST = 11'h004;
  localparam logic [DMSP_IW-1:0] DMSP_IEN_RST  = 5'h00;

  typedef struct packed {
    logic [2:0] rate;
    logic [1:0] clk_src;
    logic       two_stop;
    logic       par_odd;
    logic       par_en;
    logic       len8;
    logic [1:0] mode;
  } dmsp_ctrl_t;

  typedef struct packed {
    logic tx_adb;
    logic tx_its;
    logic rx_its;
    logic tx_ie;
    logic rx_ie;
  } dmsp_ien_t;

  typedef enum logic [2:0] {
    DMSP_TX_IDLE  = 3'h0,
    DMSP_TX_START = 3'h1,
    DMSP_TX_DATA  = 3'h3,
    DMSP_TX_EXTRA = 3'h2,
    DMSP_TX_STOP  = 3'h6,
    DMSP_TX_STOP2 = 3'h7
  } dmsp_tx_st_t;

  typedef enum logic [2:0] {
    DMSP_RX_IDLE  = 3'h0,
    DMSP_RX_START = 3'h1,
    DMSP_RX_DATA  = 3'h3,
    DMSP_RX_EXTRA = 3'h2,
    DMSP_RX_STOP  = 3'h6
  } dmsp_rx_st_t;

  function automatic logic [2:0] dmsp_last_idx(input dmsp_ctrl_t c);
    if (c.mode == DMSP_MODE_ASYNC && !c.len8) begin
      return DMSP_IDX_LAST7;
    end
    return DMSP_IDX_LAST8;
  endfunction : dmsp_last_idx

  function automatic logic dmsp_par(input logic [7:0] d,
                                    input logic [2:0] last,
                                    input logic       odd);
    logic [7:0] m;
    m = (last == DMSP_IDX_LAST7) ? 8'h7f : 8'hff;
    return (^(d & m)) ^ odd;
  endfunction : dmsp_par

endpackage : dmsp_pkg

/* File: core/dmsp_buf2.sv */
// two-entry holding buffer with valid/ready on both sides
// assumes producer and consumer share the clock
`timescale 1ns/1ps
module dmsp_buf2 #(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_r [2];
  logic         wp_r;
  logic         rp_r;
  logic [1:0]   cnt_r;
  logic         push;
  logic         pop;

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      wp_r  <= wp_r ^ push;
      rp_r  <= rp_r ^ pop;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : dmsp_buf2

/* File: core/dmsp_baud.sv */
// bit tick source: rate generator, shift clock pin or reload timer
// assumes the pin is asynchronous and the timer pulse is on our clock
`timescale 1ns/1ps
module dmsp_baud
  import dmsp_pkg::*;
#(
  parameter int DIV_W = DMSP_DIV_W
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [1:0] clk_src,
  input  wire logic [2:0] rate,
  input  wire logic       sck_pin,
  input  wire logic       rlt_uflow,
  output logic            tick
);
  logic             s1_r;
  logic             s2_r;
  logic             s3_r;
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] lim;
  logic             tick_r;

  assign lim  = (DIV_W'(1) << rate) - DIV_W'(1);
  assign tick = tick_r;

  always_ff @(posedge clock) begin
    // reset to idle high so an idle pin gives no false edge
    if (rst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= sck_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r <= (div_r >= lim) ? '0 : div_r + DIV_W'(1);
      unique case (clk_src)
        DMSP_CS_EXT: tick_r <= s2_r && !s3_r;
        DMSP_CS_RLT: tick_r <= rlt_uflow;
        default:     tick_r <= (div_r >= lim);
      endcase
    end
  end
endmodule : dmsp_baud

/* File: core/dmsp_core.sv */
// dual mode serial port: async, multiprocessor master and sync
// assumes a plain register port on the same clock as the line logic
//
// Summary of operation
// - async start-stop and clocked sync modes
// - sync mode sends no start/stop bits
// - 8-bit chars; 7-bit only async normal
// - NRZ, level held whole bit
// - framing, overrun, parity; no parity multiprocessor
// - receive request on char or error
// - send request when char sent
// - requests may start transfer service instead
// - multiprocessor master role only
// - multiprocessor: 8 data plus address flag
// - sync: 8 bits, shift clock, no parity
// - one or two stop bits; check one
// - bit clock from generator, pin, timer; sync mode takes the generator when pin is selected
// - reload timer 0 underflow usable as clock
// - eight baud rate settings
// - max rate machine clock over eight
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
module dmsp_core
  import dmsp_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic [dmsp_pkg::DMSP_AW-1:0] addr,
  input  wire logic [dmsp_pkg::DMSP_DW-1:0] wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic [dmsp_pkg::DMSP_DW-1:0]    rdata,
  input  wire logic                       rxd,
  output logic                            txd,
  input  wire logic                       sck_i,
  output logic                            sck_o,
  output logic                            sck_oe,
  input  wire logic                       rlt_uflow,
  output logic                            rx_irq,
  output logic                            tx_irq,
  output logic                            rx_its_req,
  output logic                            tx_its_req
);
  dmsp_ctrl_t            ctrl_r;
  dmsp_ien_t             ien_r;
  logic [DMSP_DW-1:0]    rdata_r;
  logic                  fe_r;
  logic                  pe_r;
  logic                  ore_r;
  logic                  txdone_r;
  logic                  rxirq_r;
  logic                  txirq_r;
  logic                  rxits_r;
  logic                  txits_r;
  logic                  txd_r;
  logic                  sck_r;
  logic                  sckoe_r;
  logic                  rxs1_r;
  logic                  rxs2_r;
  dmsp_tx_st_t           tx_st_r;
  logic [2:0]            tx_cnt_r;
  logic [2:0]            tx_idx_r;
  logic [7:0]            tx_sh_r;
  logic                  tx_ext_r;
  dmsp_rx_st_t           rx_st_r;
  logic [2:0]            rx_cnt_r;
  logic [2:0]            rx_idx_r;
  logic [7:0]            rx_sh_r;
  logic                  rx_ext_r;
  logic                  rx_push_r;
  logic [8:0]            rx_word_r;
  logic                  tick;
  logic [1:0]            eff_src;
  logic [2:0]            last;
  logic                  is_sync;
  logic                  has_extra;
  logic                  tx_end;
  logic                  rx_samp;
  logic                  rx_end;
  logic                  sck_rise;
  logic                  wr_data;
  logic                  wr_stat;
  logic                  rd_data;
  logic                  txb_ready;
  logic                  txb_valid;
  logic [8:0]            txb_data;
  logic                  txb_pop;
  logic                  rxb_ready;
  logic                  rxb_valid;
  logic [8:0]            rxb_data;
  logic                  rx_req;

  assign is_sync   = (ctrl_r.mode == DMSP_MODE_SYNC);
  assign last      = dmsp_last_idx(ctrl_r);
  assign has_extra = (ctrl_r.mode == DMSP_MODE_MP) ||
                     (ctrl_r.mode == DMSP_MODE_ASYNC && ctrl_r.par_en);
  // the pin is driven in sync mode, so it cannot also clock us then
  assign eff_src   = (is_sync && ctrl_r.clk_src == DMSP_CS_EXT) ?
                     DMSP_CS_GEN : ctrl_r.clk_src;
  assign tx_end    = tick && (tx_cnt_r == DMSP_TICK_LAST);
  assign rx_samp   = tick && (rx_cnt_r == DMSP_TICK_SAMPLE);
  assign rx_end    = tick && (rx_cnt_r == DMSP_TICK_LAST);
  assign sck_rise  = is_sync && (tx_st_r == DMSP_TX_DATA) && tick &&
                     (tx_cnt_r == DMSP_TICK_SAMPLE);
  assign wr_data   = wr && (addr == DMSP_OFS_DATA);
  assign wr_stat   = wr && (addr == DMSP_OFS_STAT);
  assign rd_data   = rd && (addr == DMSP_OFS_DATA);
  assign txb_pop   = (tx_st_r == DMSP_TX_IDLE);
  assign rx_req    = rxb_valid || fe_r || pe_r || ore_r;

  assign rdata      = rdata_r;
  assign txd        = txd_r;
  assign sck_o      = sck_r;
  assign sck_oe     = sckoe_r;
  assign rx_irq     = rxirq_r;
  assign tx_irq     = txirq_r;
  assign rx_its_req = rxits_r;
  assign tx_its_req = txits_r;

  dmsp_baud #(.DIV_W(DMSP_DIV_W)) u_baud (
    .clock     (clock),
    .rst       (rst),
    .clk_src   (eff_src),
    .rate      (ctrl_r.rate),
    .sck_pin   (sck_i),
    .rlt_uflow (rlt_uflow),
    .tick      (tick)
  );

  dmsp_buf2 #(.W(9)) u_txb (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (wr_data),
    .in_ready  (txb_ready),
    .in_data   ({ien_r.tx_adb, wdata[7:0]}),
    .out_valid (txb_valid),
    .out_ready (txb_pop),
    .out_data  (txb_data)
  );

  dmsp_buf2 #(.W(9)) u_rxb (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (rx_push_r),
    .in_ready  (rxb_ready),
    .in_data   (rx_word_r),
    .out_valid (rxb_valid),
    .out_ready (rd_data),
    .out_data  (rxb_data)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r <= dmsp_ctrl_t'(DMSP_CTRL_RST);
      ien_r  <= dmsp_ien_t'(DMSP_IEN_RST);
    end else if (wr && addr == DMSP_OFS_CTRL) begin
      ctrl_r <= dmsp_ctrl_t'(wdata[DMSP_CW-1:0]);
    end else if (wr && addr == DMSP_OFS_IEN) begin
      ien_r <= dmsp_ien_t'(wdata[DMSP_IW-1:0]);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (rd) begin
      unique case (addr)
        DMSP_OFS_CTRL: rdata_r <= DMSP_DW'(ctrl_r);
        DMSP_OFS_IEN:  rdata_r <= DMSP_DW'(ien_r);
        DMSP_OFS_DATA: rdata_r <= DMSP_DW'(rxb_valid ? rxb_data : 9'h000);
        DMSP_OFS_STAT: begin
          rdata_r                 <= '0;
          rdata_r[DMSP_ST_RXAV]   <= rxb_valid;
          rdata_r[DMSP_ST_FE]     <= fe_r;
          rdata_r[DMSP_ST_PE]     <= pe_r;
          rdata_r[DMSP_ST_ORE]    <= ore_r;
          rdata_r[DMSP_ST_TXDONE] <= txdone_r;
          rdata_r[DMSP_ST_TXRDY]  <= txb_ready;
          rdata_r[DMSP_ST_TXBUSY] <= (tx_st_r != DMSP_TX_IDLE);
        end
        default: rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  // line input passes two flops first
  always_ff @(posedge clock) begin
    if (rst) begin
      rxs1_r <= 1'b1;
      rxs2_r <= 1'b1;
    end else begin
      rxs1_r <= rxd;
      rxs2_r <= rxs1_r;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_st_r  <= DMSP_TX_IDLE;
      tx_cnt_r <= 3'h0;
      tx_idx_r <= 3'h0;
      tx_sh_r  <= 8'h00;
      tx_ext_r <= 1'b0;
      txd_r    <= 1'b1;
    end else begin
      tx_cnt_r <= (tx_st_r == DMSP_TX_IDLE) ? 3'h0 : tx_cnt_r + {2'h0, tick};
      unique case (tx_st_r)
        DMSP_TX_IDLE: begin
          if (txb_valid) begin
            tx_sh_r  <= txb_data[7:0];
            tx_idx_r <= 3'h0;
            tx_ext_r <= (ctrl_r.mode == DMSP_MODE_MP) ? txb_data[8] :
                        dmsp_par(txb_data[7:0], last, ctrl_r.par_odd);
            tx_st_r  <= is_sync ? DMSP_TX_DATA : DMSP_TX_START;
            txd_r    <= is_sync ? txb_data[0] : 1'b0;
          end
        end
        DMSP_TX_START: if (tx_end) begin
          tx_st_r <= DMSP_TX_DATA;
          txd_r   <= tx_sh_r[0];
        end
        DMSP_TX_DATA: if (tx_end) begin
          if (tx_idx_r != last) begin
            tx_idx_r <= tx_idx_r + 3'h1;
            tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
            txd_r    <= tx_sh_r[1];
          end else if (is_sync) begin
            tx_st_r <= DMSP_TX_IDLE;
            txd_r   <= 1'b1;
          end else if (has_extra) begin
            tx_st_r <= DMSP_TX_EXTRA;
            txd_r   <= tx_ext_r;
          end else begin
            tx_st_r <= DMSP_TX_STOP;
            txd_r   <= 1'b1;
          end
        end
        DMSP_TX_EXTRA: if (tx_end) begin
          tx_st_r <= DMSP_TX_STOP;
          txd_r   <= 1'b1;
        end
        DMSP_TX_STOP: if (tx_end) begin
          tx_st_r <= ctrl_r.two_stop ? DMSP_TX_STOP2 : DMSP_TX_IDLE;
        end
        DMSP_TX_STOP2: if (tx_end) begin
          tx_st_r <= DMSP_TX_IDLE;
        end
        default: tx_st_r <= DMSP_TX_IDLE;
      endcase
    end
  end

  // shift clock low then high per bit
  always_ff @(posedge clock) begin
    if (rst) begin
      sck_r   <= 1'b1;
      sckoe_r <= 1'b0;
    end else begin
      sckoe_r <= is_sync;
      sck_r   <= !(is_sync && tx_st_r == DMSP_TX_DATA &&
                   tx_cnt_r < DMSP_TICK_SCK_HI);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_st_r   <= DMSP_RX_IDLE;
      rx_cnt_r  <= 3'h0;
      rx_idx_r  <= 3'h0;
      rx_sh_r   <= 8'h00;
      rx_ext_r  <= 1'b0;
      rx_push_r <= 1'b0;
      rx_word_r <= 9'h000;
    end else begin
      rx_push_r <= 1'b0;
      rx_cnt_r  <= rx_cnt_r + {2'h0, tick};
      if (is_sync) begin
        // sync receive follows our own shift clock
        rx_st_r <= DMSP_RX_IDLE;
        if (tx_st_r == DMSP_TX_IDLE) begin
          rx_idx_r <= 3'h0;
        end else if (sck_rise) begin
          rx_sh_r[rx_idx_r] <= rxs2_r;
          rx_idx_r <= rx_idx_r + 3'h1;
          if (rx_idx_r == DMSP_IDX_LAST8) begin
            rx_push_r <= 1'b1;
            rx_word_r <= {1'b0, rxs2_r, rx_sh_r[6:0]};
          end
        end
      end else begin
        unique case (rx_st_r)
          DMSP_RX_IDLE: if (!rxs2_r) begin
            rx_st_r  <= DMSP_RX_START;
            rx_cnt_r <= 3'h0;
            rx_idx_r <= 3'h0;
            rx_sh_r  <= 8'h00;
          end
          DMSP_RX_START: begin
            if (rx_samp && rxs2_r) begin
              rx_st_r <= DMSP_RX_IDLE;
            end else if (rx_end) begin
              rx_st_r <= DMSP_RX_DATA;
            end
          end
          DMSP_RX_DATA: begin
            if (rx_samp) begin
              rx_sh_r[rx_idx_r] <= rxs2_r;
            end
            if (rx_end) begin
              rx_idx_r <= rx_idx_r + 3'h1;
              if (rx_idx_r == last) begin
                rx_st_r <= has_extra ? DMSP_RX_EXTRA : DMSP_RX_STOP;
              end
            end
          end
          DMSP_RX_EXTRA: begin
            if (rx_samp) begin
              rx_ext_r <= rxs2_r;
            end
            if (rx_end) begin
              rx_st_r <= DMSP_RX_STOP;
            end
          end
          DMSP_RX_STOP: if (rx_samp) begin
            rx_st_r   <= DMSP_RX_IDLE;
            rx_push_r <= 1'b1;
            rx_word_r <= {rx_ext_r, rx_sh_r};
          end
          default: rx_st_r <= DMSP_RX_IDLE;
        endcase
      end
    end
  end

  // error and done flags: hardware set beats software clear
  always_ff @(posedge clock) begin
    if (rst) begin
      fe_r     <= 1'b0;
      pe_r     <= 1'b0;
      ore_r    <= 1'b0;
      txdone_r <= 1'b0;
    end else begin
      if (wr_stat && wdata[DMSP_ST_FE])     fe_r     <= 1'b0;
      if (wr_stat && wdata[DMSP_ST_PE])     pe_r     <= 1'b0;
      if (wr_stat && wdata[DMSP_ST_ORE])    ore_r    <= 1'b0;
      if (wr_stat && wdata[DMSP_ST_TXDONE]) txdone_r <= 1'b0;
      if (!is_sync && rx_st_r == DMSP_RX_STOP && rx_samp && !rxs2_r) begin
        fe_r <= 1'b1;
      end
      if (!is_sync && rx_st_r == DMSP_RX_STOP && rx_samp &&
          ctrl_r.mode == DMSP_MODE_ASYNC && ctrl_r.par_en &&
          dmsp_par(rx_sh_r, last, ctrl_r.par_odd) != rx_ext_r) begin
        pe_r <= 1'b1;
      end
      if (rx_push_r && !rxb_ready) begin
        ore_r <= 1'b1;
      end
      if (tx_st_r != DMSP_TX_IDLE && tx_end &&
          ((tx_st_r == DMSP_TX_DATA && is_sync && tx_idx_r == last) ||
           (tx_st_r == DMSP_TX_STOP && !ctrl_r.two_stop) ||
           tx_st_r == DMSP_TX_STOP2)) begin
        txdone_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rxirq_r <= 1'b0;
      txirq_r <= 1'b0;
      rxits_r <= 1'b0;
      txits_r <= 1'b0;
    end else begin
      rxirq_r <= ien_r.rx_ie && !ien_r.rx_its && rx_req;
      rxits_r <= ien_r.rx_ie && ien_r.rx_its && rx_req;
      txirq_r <= ien_r.tx_ie && !ien_r.tx_its && txdone_r;
      txits_r <= ien_r.tx_ie && ien_r.tx_its && txdone_r;
    end
  end

  sequence s_tx_leave_data;
    tx_st_r == DMSP_TX_DATA && tx_end && tx_idx_r == last;
  endsequence

  sequence s_char_in;
    rx_push_r && rxb_ready && ien_r.rx_ie && !ien_r.rx_its;
  endsequence

  property p_sync_nostart;
    @(posedge clock) disable iff (rst)
      is_sync && tx_st_r == DMSP_TX_IDLE |=> tx_st_r != DMSP_TX_START;
  endproperty
  a_sync_nostart: assert property (p_sync_nostart)
    else $error("start bit in sync mode");

  property p_len7;
    @(posedge clock) disable iff (rst)
      ctrl_r.mode != DMSP_MODE_ASYNC |-> last == DMSP_IDX_LAST8;
  endproperty
  a_len7: assert property (p_len7)
    else $error("seven bit length outside async normal");

  property p_nrz;
    @(posedge clock) disable iff (rst)
      tx_st_r != DMSP_TX_IDLE && !tx_end |=> $stable(txd_r);
  endproperty
  a_nrz: assert property (p_nrz)
    else $error("line changed inside a bit");

  property p_mp_nopar;
    @(posedge clock) disable iff (rst)
      ctrl_r.mode == DMSP_MODE_MP && !pe_r |=> !pe_r;
  endproperty
  a_mp_nopar: assert property (p_mp_nopar)
    else $error("parity error in multiprocessor mode");

  property p_rx_req;
    @(posedge clock) disable iff (rst)
      s_char_in ##1 ien_r.rx_ie && !ien_r.rx_its |=> rxirq_r;
  endproperty
  a_rx_req: assert property (p_rx_req)
    else $error("no receive request after character");

  property p_tx_done;
    @(posedge clock) disable iff (rst)
      tx_st_r == DMSP_TX_STOP2 && tx_end |=> txdone_r;
  endproperty
  a_tx_done: assert property (p_tx_done)
    else $error("send complete not flagged");

  property p_its_excl;
    @(posedge clock) disable iff (rst)
      !(rxirq_r && rxits_r) && !(txirq_r && txits_r);
  endproperty
  a_its_excl: assert property (p_its_excl)
    else $error("request sent both ways");

  property p_mp_extra;
    @(posedge clock) disable iff (rst)
      s_tx_leave_data ##0 ctrl_r.mode == DMSP_MODE_MP
        |=> tx_st_r == DMSP_TX_EXTRA && txd_r == tx_ext_r;
  endproperty
  a_mp_extra: assert property (p_mp_extra)
    else $error("address flag bit missing");

  property p_sync_end;
    @(posedge clock) disable iff (rst)
      s_tx_leave_data ##0 is_sync |=> tx_st_r == DMSP_TX_IDLE ##1 txdone_r;
  endproperty
  a_sync_end: assert property (p_sync_end)
    else $error("sync frame not ended after data");

  property p_stop2;
    @(posedge clock) disable iff (rst)
      tx_st_r == DMSP_TX_STOP && tx_end && ctrl_r.two_stop
        |=> tx_st_r == DMSP_TX_STOP2 && txd_r;
  endproperty
  a_stop2: assert property (p_stop2)
    else $error("second stop bit missing");

  property p_overrun;
    @(posedge clock) disable iff (rst)
      rx_push_r && !rxb_ready |=> ore_r;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");

endmodule : dmsp_core

/* File: verification/dmsp_peer.sv */
// far-side serial device: sends start-stop frames on the receive line
// assumes rate 0, so one bit lasts eight clocks
`timescale 1ns/1ps
module dmsp_peer (
  input  wire logic clock,
  output logic      rxd
);
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] d, input logic stop_lvl);
    logic [9:0] f;
    f = {stop_lvl, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (8) @(posedge clock);
    end
    // line idles high, like a pull-up after the frame
    rxd <= 1'b1;
    repeat (8) @(posedge clock);
  endtask : send
endmodule : dmsp_peer

/* File: verification/dmsp_core_tb_top.sv */
// bench for the serial port: register tasks, line checks, peer model
// assumes rate 0 async 8 bit, so a bit is eight clocks
`timescale 1ns/1ps
module dmsp_core_tb_top;
  import dmsp_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata, v;
  logic        rxd, txd, rx_irq, tx_irq, rx_its_req, tx_its_req;
  logic        sck_o, sck_oe;
  logic        rlt = 1'b0;
  logic        rlt_on = 1'b0;
  logic [11:0] fr;
  int          n_fail = 0;
  int          n_compared = 0;
  always #20 clock = ~clock;
  // one pulse every other clock feeds both the timer and the pin source
  always @(posedge clock) rlt <= rlt_on && !rlt;
  dmsp_peer u_dmsp_peer (.clock(clock), .rxd(rxd));
  dmsp_core u_dmsp_core (.clock(clock), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd),
    .txd(txd), .sck_i(rlt), .sck_o(sck_o), .sck_oe(sck_oe), .rlt_uflow(rlt),
    .rx_irq(rx_irq), .tx_irq(tx_irq), .rx_its_req(rx_its_req),
    .tx_its_req(tx_its_req));
  task automatic chk(input string nm, input logic [15:0] s, e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a; rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask : rd_reg
  task automatic cap(input int n, input int per);
    fr = '0;
    for (int i = 0; i < 400 && txd !== 1'b0; i++) @(negedge clock);
    // sample each bit in its middle
    repeat (per / 2) @(negedge clock);
    for (int i = 0; i < n; i++) begin
      fr[i] = txd;
      repeat (per) @(negedge clock);
    end
  endtask : cap
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  initial begin
    #(40 * 6000);
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd_reg(DMSP_OFS_CTRL, v); chk("ctrl", v, 16'h0004);
    rd_reg(4'h2, v); chk("unmapped", v, 16'h0000);
    rd_reg(DMSP_OFS_STAT, v); chk("stat", v, 16'h0020);
    $display("reset test done");
    wr_reg(DMSP_OFS_IEN, 16'h0007);
    wr_reg(DMSP_OFS_DATA, 16'h00a5);
    cap(10, 8);
    chk("tx frame", {4'h0, fr}, {6'h0, 1'b1, 8'ha5, 1'b0});
    repeat (4) @(posedge clock);
    chk("tx irq", {15'h0, tx_irq}, 16'h0001);
    rd_reg(DMSP_OFS_STAT, v);
    chk("tx done", v & 16'h0010, 16'h0010);
    wr_reg(DMSP_OFS_STAT, 16'h001e);
    $display("tx test done");
    u_dmsp_peer.send(8'h3c, 1'b1);
    chk("rx its", {15'h0, rx_its_req}, 16'h0001);
    chk("rx irq off", {15'h0, rx_irq}, 16'h0000);
    rd_reg(DMSP_OFS_STAT, v);
    chk("rx avail", v & 16'h000f, 16'h0001);
    rd_reg(DMSP_OFS_DATA, v);
    chk("rx data", v & 16'h00ff, 16'h003c);
    $display("rx test done");
    u_dmsp_peer.send(8'h55, 1'b0);
    rd_reg(DMSP_OFS_STAT, v);
    chk("frame err", v & 16'h0002, 16'h0002);
    rd_reg(DMSP_OFS_DATA, v);
    wr_reg(DMSP_OFS_STAT, 16'h001e);
    $display("framing test done");
    wr_reg(DMSP_OFS_IEN, 16'h0003);
    for (int i = 0; i < 3; i++) u_dmsp_peer.send(8'h10 + 8'(i), 1'b1);
    chk("rx irq", {15'h0, rx_irq}, 16'h0001);
    rd_reg(DMSP_OFS_STAT, v);
    chk("overrun", v & 16'h0008, 16'h0008);
    rd_reg(DMSP_OFS_DATA, v);
    chk("first kept", v & 16'h00ff, 16'h0010);
    $display("overrun test done");
    wr_reg(DMSP_OFS_CTRL, 16'h0025);
    wr_reg(DMSP_OFS_IEN, 16'h001a);
    wr_reg(DMSP_OFS_DATA, 16'h0081);
    cap(12, 8);
    chk("mp frame", {4'h0, fr}, {4'h0, 3'h7, 8'h81, 1'b0});
    chk("tx its", {15'h0, tx_its_req}, 16'h0001);
    chk("tx irq off", {15'h0, tx_irq}, 16'h0000);
    wr_reg(DMSP_OFS_STAT, 16'h001e);
    $display("multiprocessor test done");
    wr_reg(DMSP_OFS_CTRL, 16'h0006);
    wr_reg(DMSP_OFS_DATA, 16'h005a);
    chk("sck oe", {15'h0, sck_oe}, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 20 && sck_o !== 1'b0; j++) @(negedge clock);
      for (int j = 0; j < 20 && sck_o !== 1'b1; j++) @(negedge clock);
      fr[i] = txd;
    end
    // first shift clock already carries data bit 0
    chk("sync data", {8'h0, fr[7:0]}, 16'h005a);
    repeat (8) @(posedge clock);
    $display("sync test done");
    rlt_on <= 1'b1;
    wr_reg(DMSP_OFS_CTRL, 16'h0084);
    wr_reg(DMSP_OFS_DATA, 16'h0033);
    cap(10, 16);
    chk("timer frame", {4'h0, fr}, {6'h0, 1'b1, 8'h33, 1'b0});
    wr_reg(DMSP_OFS_CTRL, 16'h0044);
    wr_reg(DMSP_OFS_DATA, 16'h00c3);
    cap(10, 16);
    chk("pin frame", {4'h0, fr}, {6'h0, 1'b1, 8'hc3, 1'b0});
    $display("clock source test done");
    stop_test();
  end
endmodule : dmsp_core_tb_top
